// [logic/asi_consts.svh]
// Purpose: offsets, field positions and reset values of the port status block
// Assumes: byte addressed register window, one 32-bit word per register
// Notes:   threshold setup register is local to this block
`ifndef ASI_CONSTS_SVH
`define ASI_CONSTS_SVH

`define ASI_ADDR_W          5
`define ASI_OFS_IRQ_ENABLE  5'h08
`define ASI_OFS_PORT_STATUS 5'h0C
`define ASI_OFS_THRESHOLD   5'h10

`define ASI_FIFO_DEPTH      4'h8
`define ASI_LEVEL_EMPTY     4'h0

// irq_enable fields
`define ASI_IE_LZC          12
`define ASI_IE_RZC          11
`define ASI_IE_TX_THRESHOLD_SETTING         10
`define ASI_IE_TX_OVERFLOW_FLAG        9
`define ASI_IE_TX_UNDERFLOW_FLAG        8
`define ASI_IE_RX_THRESHOLD_SETTING         2
`define ASI_IE_RXOVF        1
`define ASI_IE_RX_UNDERFLOW_FLAG        0
`define ASI_IE_MASK         32'h00001F07
`define ASI_IE_TX_GROUP     32'h00001F00
`define ASI_IE_RX_GROUP     32'h00000007
`define ASI_IE_RESET        32'h00000000

// port_status fields
`define ASI_ST_TXLVL_HI     31
`define ASI_ST_TXLVL_LO     28
`define ASI_ST_RXLVL_HI     27
`define ASI_ST_RXLVL_LO     24
`define ASI_ST_LZC          23
`define ASI_ST_RZC          22
`define ASI_ST_TXBUSY       21
`define ASI_ST_TXEMPTY      20
`define ASI_ST_TX_FIFO_FULL_FLAG       19
`define ASI_ST_TX_THRESHOLD_SETTING         18
`define ASI_ST_TX_OVERFLOW_FLAG        17
`define ASI_ST_TX_UNDERFLOW_FLAG        16
`define ASI_ST_RXEMPTY      12
`define ASI_ST_RXFULL       11
`define ASI_ST_RX_THRESHOLD_SETTING         10
`define ASI_ST_RXOVF        9
`define ASI_ST_RX_UNDERFLOW_FLAG        8
`define ASI_ST_TXINT        2
`define ASI_ST_RXINT        1
`define ASI_ST_INT          0
`define ASI_ST_RESET        32'h00141000

// threshold setup fields
`define ASI_TH_TX_HI        2
`define ASI_TH_TX_LO        0
`define ASI_TH_RX_HI        6
`define ASI_TH_RX_LO        4
`define ASI_TH_RESET        3'h0
// rx threshold of one keeps the receive threshold flag low in the status reset value
`define ASI_TH_RX_RESET     3'h1

`endif

// [logic/asi_pkg.sv]
// Purpose: state types of the port status block
// Assumes: constants come from asi_consts.svh
// Notes:   one packed struct per module
package asi_pkg;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic        rise;
        logic        fall;
    } asi_sync_state_type;

    typedef struct packed {
        logic [1:0]  prev_sign;
        logic [1:0]  hit;
    } asi_zc_state_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [31:0] irq_en;
        logic [2:0]  tx_th;
        logic [2:0]  rx_th;
        logic        lzc;
        logic        rzc;
        logic        tx_ovf;
        logic        tx_udf;
        logic        rx_ovf;
        logic        rx_udf;
        logic        tx_th_flag;
        logic        tx_wr_pend;
        logic        irq;
    } asi_state_type;

endpackage

// [logic/asi_link_sync.sv]
// Purpose: two-flop synchroniser with edge pulses for the word select pin
// Assumes: pin toggles far slower than i_clk
// Notes:   first flop feeds only the second
module asi_link_sync (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);
    asi_pkg::asi_sync_state_type s_q;
    asi_pkg::asi_sync_state_type s_d;

    always_comb begin
        s_d      = s_q;
        s_d.s1   = i_pin;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        s_d.rise = s_q.s2 & ~s_q.s3;
        s_d.fall = ~s_q.s2 & s_q.s3;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            // idle high pin, no false edge after reset
            s_q <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rise = s_q.rise;
    assign o_fall = s_q.fall;
endmodule

// [logic/asi_zero_cross.sv]
// Purpose: per channel zero crossing detector on outgoing samples
// Assumes: i_eval pulses once per channel word, i_left names the channel
// Notes:   hit pulses last one cycle
module asi_zero_cross #(
    parameter int DW = 16
) (
    input  wire logic          i_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_eval,
    input  wire logic          i_left,
    input  wire logic [DW-1:0] i_sample,
    output logic               o_left_hit,
    output logic               o_right_hit
);
    asi_pkg::asi_zc_state_type s_q;
    asi_pkg::asi_zc_state_type s_d;
    logic                      idx;

    if (DW < 2) begin : g_bad_width
        $error("sample width below two bits");
    end

    always_comb begin
        s_d     = s_q;
        idx     = i_left;
        s_d.hit = 2'h0;
        if (i_eval) begin
            // sign change or all zero data
            s_d.hit[idx]       = (i_sample[DW-1] != s_q.prev_sign[idx]) |
                                 (i_sample == '0);
            s_d.prev_sign[idx] = i_sample[DW-1];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_left_hit  = s_q.hit[1];
    assign o_right_hit = s_q.hit[0];

    property p_left_zero;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_eval && i_left && i_sample == '0) |=> o_left_hit;
    endproperty
    a_left_zero: assert property (p_left_zero)
        else $error("left zero sample not flagged");

    property p_right_zero;
        @(posedge i_clk) disable iff (!i_arst_n)
        (i_eval && !i_left && i_sample == '0) |=> o_right_hit;
    endproperty
    a_right_zero: assert property (p_right_zero)
        else $error("right zero sample not flagged");
endmodule

// [logic/asi_port_status.sv]
// Purpose: interrupt enable and status registers of the audio serial port
// Assumes: fifo levels and strobes come from logic on i_clk
// Notes:   word select pin is synchronised before use
//
// Overview of operation
// - left zero-cross flag with enable bit 12 requests an interrupt
// - enable bit 11 permits or blocks the right zero-cross interrupt
// - enable bit 10 with transmit threshold flag (count at or below threshold) raises interrupt
// - enable bit 9 with transmit overflow flag raises interrupt
// - enable bit 8 with transmit underflow flag raises interrupt
// - receive threshold flag when count reaches threshold; enable bit 2 interrupts
// - enable bit 1 permits or blocks the receive overflow interrupt
// - receive read while empty sets underflow flag; enable bit 0 gates it
// - status bits 31:28 show transmit fifo count, zero to eight
// - status bits 27:24 show receive fifo count, zero to eight
// - bit 23 sets on left sample sign change or all-zero data
// - bit 22 sets on right sample sign change or all-zero data
// - zero-cross flags stay set until software writes one
// - write to full transmit fifo sets sticky overflow flag, write-one clears
// - fetch from empty transmit fifo sets sticky underflow flag
// - transmit threshold flag high at or below threshold, falls after write
// - transmit full flag is read-only and high exactly at eight words
`include "asi_consts.svh"

module asi_port_status #(
    parameter int DW = 16
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_arst_n,
    input  wire logic [`ASI_ADDR_W-1:0] i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic [31:0]                 o_avs_readdata,
    output logic                        o_avs_waitrequest,
    input  wire logic                   i_lrclk,
    input  wire logic [DW-1:0]          i_tx_sample,
    input  wire logic [3:0]             i_tx_level,
    input  wire logic [3:0]             i_rx_level,
    input  wire logic                   i_tx_push,
    input  wire logic                   i_tx_pop,
    input  wire logic                   i_rx_push,
    input  wire logic                   i_rx_pop,
    input  wire logic                   i_tx_busy,
    output logic                        o_irq
);
    asi_pkg::asi_state_type s_q;
    asi_pkg::asi_state_type s_d;

    logic        ws_rise;
    logic        ws_fall;
    logic        left_hit;
    logic        right_hit;
    logic        req;
    logic        wr_take;
    logic [31:0] wmask;
    logic [31:0] wdata;
    logic [31:0] w1c;
    logic [31:0] status_word;
    logic [31:0] pend_vec;
    logic        rx_th_now;
    logic        tx_full;

    if (DW < 2) begin : g_bad_width
        $error("sample width below two bits");
    end

    // byte address compare against a register offset
    function automatic logic asi_hit(input logic [`ASI_ADDR_W-1:0] addr,
                                     input logic [`ASI_ADDR_W-1:0] ofs);
        asi_hit = (addr == ofs);
    endfunction

    asi_link_sync u_ws_sync (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_pin    (i_lrclk),
        .o_rise   (ws_rise),
        .o_fall   (ws_fall)
    );

    // low word select starts the left word
    asi_zero_cross #(
        .DW (DW)
    ) u_zero_cross (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_eval      (ws_rise | ws_fall),
        .i_left      (ws_fall),
        .i_sample    (i_tx_sample),
        .o_left_hit  (left_hit),
        .o_right_hit (right_hit)
    );

    always_comb begin
        s_d = s_q;

        // bus slave: one wait cycle, then the access completes
        req     = i_avs_read | i_avs_write;
        s_d.ack = req & ~s_q.ack;
        wr_take = i_avs_write & s_q.ack;
        wmask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        wdata   = i_avs_writedata & wmask;
        w1c     = '0;

        if (wr_take && asi_hit(i_avs_address, `ASI_OFS_IRQ_ENABLE)) begin
            s_d.irq_en = ((s_q.irq_en & ~wmask) | wdata) & `ASI_IE_MASK;
        end
        if (wr_take && asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS)) begin
            w1c = wdata;
        end
        if (wr_take && asi_hit(i_avs_address, `ASI_OFS_THRESHOLD)) begin
            if (i_avs_byteenable[0]) begin
                s_d.tx_th = i_avs_writedata[`ASI_TH_TX_HI:`ASI_TH_TX_LO];
                s_d.rx_th = i_avs_writedata[`ASI_TH_RX_HI:`ASI_TH_RX_LO];
            end
        end

        // sticky flags, a set in the clearing cycle wins
        s_d.lzc    = (s_q.lzc & ~w1c[`ASI_ST_LZC]) | left_hit;
        s_d.rzc    = (s_q.rzc & ~w1c[`ASI_ST_RZC]) | right_hit;
        s_d.tx_ovf = (s_q.tx_ovf & ~w1c[`ASI_ST_TX_OVERFLOW_FLAG]) |
                     (i_tx_push & (i_tx_level == `ASI_FIFO_DEPTH));
        s_d.tx_udf = (s_q.tx_udf & ~w1c[`ASI_ST_TX_UNDERFLOW_FLAG]) |
                     (i_tx_pop & (i_tx_level == `ASI_LEVEL_EMPTY));
        s_d.rx_ovf = (s_q.rx_ovf & ~w1c[`ASI_ST_RXOVF]) |
                     (i_rx_push & (i_rx_level == `ASI_FIFO_DEPTH));
        s_d.rx_udf = (s_q.rx_udf & ~w1c[`ASI_ST_RX_UNDERFLOW_FLAG]) |
                     (i_rx_pop & (i_rx_level == `ASI_LEVEL_EMPTY));

        // transmit threshold: set at or below, falls after a write lifts it
        if (i_tx_level <= {1'b0, s_q.tx_th}) begin
            s_d.tx_th_flag = 1'b1;
            s_d.tx_wr_pend = i_tx_push;
        end else if (s_q.tx_wr_pend || i_tx_push) begin
            s_d.tx_th_flag = 1'b0;
            s_d.tx_wr_pend = 1'b0;
        end

        rx_th_now = (i_rx_level >= {1'b0, s_q.rx_th});
        tx_full   = (i_tx_level == `ASI_FIFO_DEPTH);

        // pending sources laid out as the enable register
        pend_vec                 = '0;
        pend_vec[`ASI_IE_LZC]    = s_d.lzc;
        pend_vec[`ASI_IE_RZC]    = s_d.rzc;
        pend_vec[`ASI_IE_TX_THRESHOLD_SETTING]   = s_d.tx_th_flag;
        pend_vec[`ASI_IE_TX_OVERFLOW_FLAG]  = s_d.tx_ovf;
        pend_vec[`ASI_IE_TX_UNDERFLOW_FLAG]  = s_d.tx_udf;
        pend_vec[`ASI_IE_RX_THRESHOLD_SETTING]   = rx_th_now;
        pend_vec[`ASI_IE_RXOVF]  = s_d.rx_ovf;
        pend_vec[`ASI_IE_RX_UNDERFLOW_FLAG]  = s_d.rx_udf;
        s_d.irq = |(pend_vec & s_d.irq_en);

        // status read image
        status_word = '0;
        status_word[`ASI_ST_TXLVL_HI:`ASI_ST_TXLVL_LO] = i_tx_level;
        status_word[`ASI_ST_RXLVL_HI:`ASI_ST_RXLVL_LO] = i_rx_level;
        status_word[`ASI_ST_LZC]     = s_q.lzc;
        status_word[`ASI_ST_RZC]     = s_q.rzc;
        status_word[`ASI_ST_TXBUSY]  = i_tx_busy;
        status_word[`ASI_ST_TXEMPTY] = (i_tx_level == `ASI_LEVEL_EMPTY);
        status_word[`ASI_ST_TX_FIFO_FULL_FLAG]  = tx_full;
        status_word[`ASI_ST_TX_THRESHOLD_SETTING]    = s_q.tx_th_flag;
        status_word[`ASI_ST_TX_OVERFLOW_FLAG]   = s_q.tx_ovf;
        status_word[`ASI_ST_TX_UNDERFLOW_FLAG]   = s_q.tx_udf;
        status_word[`ASI_ST_RXEMPTY] = (i_rx_level == `ASI_LEVEL_EMPTY);
        status_word[`ASI_ST_RXFULL]  = (i_rx_level == `ASI_FIFO_DEPTH);
        status_word[`ASI_ST_RX_THRESHOLD_SETTING]    = rx_th_now;
        status_word[`ASI_ST_RXOVF]   = s_q.rx_ovf;
        status_word[`ASI_ST_RX_UNDERFLOW_FLAG]   = s_q.rx_udf;
        status_word[`ASI_ST_TXINT]   = |(pend_vec & s_q.irq_en & `ASI_IE_TX_GROUP);
        status_word[`ASI_ST_RXINT]   = |(pend_vec & s_q.irq_en & `ASI_IE_RX_GROUP);
        status_word[`ASI_ST_INT]     = s_q.irq;

        // read data captured in the wait cycle, unmapped reads give zero
        if (i_avs_read && !s_q.ack) begin
            if (asi_hit(i_avs_address, `ASI_OFS_IRQ_ENABLE)) begin
                s_d.rdata = s_q.irq_en;
            end else if (asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS)) begin
                s_d.rdata = status_word;
            end else if (asi_hit(i_avs_address, `ASI_OFS_THRESHOLD)) begin
                s_d.rdata = {25'h0, s_q.rx_th, 1'b0, s_q.tx_th};
            end else begin
                s_d.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q            <= '0;
            s_q.irq_en     <= `ASI_IE_RESET;
            s_q.tx_th      <= `ASI_TH_RESET;
            s_q.rx_th      <= `ASI_TH_RX_RESET;
            s_q.tx_th_flag <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_avs_readdata    = s_q.rdata;
    assign o_avs_waitrequest = req & ~s_q.ack;
    assign o_irq             = s_q.irq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_left_irq;
        (s_q.lzc && s_q.irq_en[`ASI_IE_LZC]) |-> o_irq;
    endproperty
    a_left_irq: assert property (p_left_irq)
        else $error("left zero-cross interrupt missing");

    property p_right_gate;
        (s_q.irq_en == 32'h00000800) |-> o_irq == s_q.rzc;
    endproperty
    a_right_gate: assert property (p_right_gate)
        else $error("right zero-cross interrupt gate wrong");

    property p_tx_ovf_set;
        (i_tx_push && i_tx_level == `ASI_FIFO_DEPTH)
            |=> s_q.tx_ovf && (o_irq || !s_q.irq_en[`ASI_IE_TX_OVERFLOW_FLAG]);
    endproperty
    a_tx_ovf_set: assert property (p_tx_ovf_set)
        else $error("transmit overflow not flagged");

    property p_tx_ovf_hold;
        (s_q.tx_ovf && !(wr_take && asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS)
            && wdata[`ASI_ST_TX_OVERFLOW_FLAG])) |=> s_q.tx_ovf;
    endproperty
    a_tx_ovf_hold: assert property (p_tx_ovf_hold)
        else $error("transmit overflow lost without write of one");

    property p_tx_udf_irq;
        (i_tx_pop && i_tx_level == `ASI_LEVEL_EMPTY)
            |=> s_q.tx_udf && (o_irq || !s_q.irq_en[`ASI_IE_TX_UNDERFLOW_FLAG]);
    endproperty
    a_tx_udf_irq: assert property (p_tx_udf_irq)
        else $error("transmit underflow interrupt missing");

    property p_tx_th_irq;
        (s_q.tx_th_flag && s_q.irq_en[`ASI_IE_TX_THRESHOLD_SETTING]) |-> o_irq;
    endproperty
    a_tx_th_irq: assert property (p_tx_th_irq)
        else $error("transmit threshold interrupt missing");

    property p_rx_ovf_irq;
        (s_q.rx_ovf && s_q.irq_en[`ASI_IE_RXOVF]) |-> o_irq;
    endproperty
    a_rx_ovf_irq: assert property (p_rx_ovf_irq)
        else $error("receive overflow interrupt missing");

    property p_full_read;
        (i_avs_read && !s_q.ack && asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS))
            |=> o_avs_readdata[`ASI_ST_TX_FIFO_FULL_FLAG] == ($past(i_tx_level) == `ASI_FIFO_DEPTH);
    endproperty
    a_full_read: assert property (p_full_read)
        else $error("transmit full flag misreported");

    property p_rx_udf_set;
        (i_rx_pop && i_rx_level == `ASI_LEVEL_EMPTY) |=> s_q.rx_udf;
    endproperty
    a_rx_udf_set: assert property (p_rx_udf_set)
        else $error("receive underflow not flagged");

    property p_rx_th_irq;
        (i_rx_level >= {1'b0, s_q.rx_th} && s_q.irq_en[`ASI_IE_RX_THRESHOLD_SETTING] && !i_avs_write)
            |=> o_irq;
    endproperty
    a_rx_th_irq: assert property (p_rx_th_irq)
        else $error("receive threshold interrupt missing");

    property p_tx_th_flag;
        (i_tx_level <= {1'b0, s_q.tx_th}) |=> s_q.tx_th_flag;
    endproperty
    a_tx_th_flag: assert property (p_tx_th_flag)
        else $error("transmit threshold flag low at or below threshold");

    property p_zc_hold;
        (s_q.lzc && !(wr_take && asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS)
            && wdata[`ASI_ST_LZC])) |=> s_q.lzc;
    endproperty
    a_zc_hold: assert property (p_zc_hold)
        else $error("zero-cross flag lost without write of one");

    property p_level_read;
        (i_avs_read && !s_q.ack && asi_hit(i_avs_address, `ASI_OFS_PORT_STATUS))
            |=> o_avs_readdata[31:24] == {$past(i_tx_level), $past(i_rx_level)}
                && !o_avs_waitrequest;
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("fifo levels misreported");

    property p_irq_idle;
        (s_q.irq_en == 32'h0) |-> !o_irq;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("interrupt with every source disabled");
endmodule

// [dv/asi_codec_model.sv]
// Purpose: far side codec model, makes the word select pin
// Assumes: 800 ns frame, low half is the left word
// Notes:   pin stands still high outside frames
module asi_codec_model #(
    parameter int HALF_NS = 400
) (
    input  wire logic i_run,
    output logic      o_lrclk
);
    timeunit 1ns;
    timeprecision 1ns;

    // offset after each start keeps pin edges off the bench clock edges
    initial begin
        o_lrclk = 1'b1;
        forever begin
            @(posedge i_run);
            #37;
            while (i_run) begin
                #HALF_NS o_lrclk = ~o_lrclk;
                #HALF_NS o_lrclk = ~o_lrclk;
            end
        end
    end
endmodule

// [dv/test_audio_serial_irq_status.sv]
// Purpose: self-checking bench of the port status block
// Assumes: Avalon master with waitrequest, fixed seed
// Notes:   status fields compared under masks
`include "asi_consts.svh"

module test_audio_serial_irq_status;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [4:0]  A_IE = `ASI_OFS_IRQ_ENABLE;
    localparam logic [4:0]  A_ST = `ASI_OFS_PORT_STATUS;
    localparam logic [4:0]  A_TH = `ASI_OFS_THRESHOLD;
    localparam logic [31:0] ZC   = 32'h00C00000;
    localparam logic [31:0] LIVE = 32'hFF381800;
    localparam logic [31:0] ALL  = 32'hFFFFFFFF;

    logic        i_clk;
    logic        i_arst_n;
    logic [4:0]  adr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        wreq;
    logic        lrclk;
    logic        link_run;
    logic [15:0] smp;
    logic [3:0]  tx_lvl;
    logic [3:0]  rx_lvl;
    logic [3:0]  strb;
    logic        busy;
    logic        irq;
    int          failures;
    int          n_checks;
    int          seed;

    asi_port_status dut (
        .i_clk            (i_clk),
        .i_arst_n         (i_arst_n),
        .i_avs_address    (adr),
        .i_avs_read       (rd_en),
        .i_avs_write      (wr_en),
        .i_avs_writedata  (wdat),
        .i_avs_byteenable (4'hF),
        .o_avs_readdata   (rdat),
        .o_avs_waitrequest(wreq),
        .i_lrclk          (lrclk),
        .i_tx_sample      (smp),
        .i_tx_level       (tx_lvl),
        .i_rx_level       (rx_lvl),
        .i_tx_push        (strb[0]),
        .i_tx_pop         (strb[1]),
        .i_rx_push        (strb[2]),
        .i_rx_pop         (strb[3]),
        .i_tx_busy        (busy),
        .o_irq            (irq)
    );

    asi_codec_model u_codec (
        .i_run  (link_run),
        .o_lrclk(lrclk)
    );

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one bus access, entered and left just after a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        adr   <= a;
        wr_en <= w;
        rd_en <= ~w;
        wdat  <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40) begin
            failures++;
            $display("[FAIL] bus answer expected 0 seen 1");
        end
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, e & m, q & m);
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge i_clk);
        check("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic set_lvl(input logic [3:0] t, input logic [3:0] r, input logic b);
        tx_lvl <= t;
        rx_lvl <= r;
        busy   <= b;
        @(posedge i_clk);
    endtask

    task automatic pulse(input int k);
        strb[k] <= 1'b1;
        @(posedge i_clk);
        strb <= 4'h0;
        @(posedge i_clk);
    endtask

    task automatic frames(input logic [15:0] s);
        smp      <= s;
        link_run <= 1'b1;
        repeat (16) @(posedge i_clk);
        link_run <= 1'b0;
        repeat (12) @(posedge i_clk);
    endtask

    // live status fields from fifo levels and busy
    function automatic logic [31:0] exp_live(logic [3:0] t, logic [3:0] r, logic b);
        logic [31:0] e;
        e        = 32'h0;
        e[31:28] = t;
        e[27:24] = r;
        e[21]    = b;
        e[20]    = (t == 4'h0);
        e[19]    = (t == 4'h8);
        e[12]    = (r == 4'h0);
        e[11]    = (r == 4'h8);
        return e;
    endfunction

    initial begin
        repeat (30000) @(posedge i_clk);
        failures++;
        finish_test();
    end

    initial begin
        int          st[4] = '{17, 16, 9, 8};
        int          ie[4] = '{9, 8, 1, 0};
        logic [31:0] v;
        logic [3:0]  t;
        logic [3:0]  r;
        seed = 32'hCDF1;
        {adr, rd_en, wr_en, wdat, link_run, smp, tx_lvl, rx_lvl, strb, busy} = '0;
        i_arst_n = 1'b0;
        repeat (4) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        rdchk(A_IE, ALL, `ASI_IE_RESET, "irq_enable reset");
        rdchk(A_ST, ALL, `ASI_ST_RESET, "status reset");
        // zero crossing on outgoing samples
        frames(16'h1234);
        rdchk(A_ST, ZC, 32'h0, "zc none");
        frames(16'h8001);
        rdchk(A_ST, ZC, ZC, "zc sign");
        wr(A_IE, 32'h00001000);
        chk_irq(1'b1);
        wr(A_IE, 32'h0);
        chk_irq(1'b0);
        wr(A_ST, 32'h00800000);
        rdchk(A_ST, ZC, 32'h00400000, "zc left clr");
        wr(A_IE, 32'h00000800);
        chk_irq(1'b1);
        wr(A_ST, 32'h0);
        rdchk(A_ST, ZC, 32'h00400000, "zc hold");
        wr(A_ST, 32'h00400000);
        chk_irq(1'b0);
        frames(16'h8002);
        rdchk(A_ST, ZC, 32'h0, "zc same sign");
        frames(16'h0000);
        wr(A_ST, ZC);
        frames(16'h0000);
        rdchk(A_ST, ZC, ZC, "zc all zero");
        wr(A_ST, ZC);
        wr(A_IE, 32'h0);
        // sticky fifo error flags, one source at a time
        for (int k = 0; k < 4; k++) begin
            set_lvl(k == 0 ? 4'h8 : (k == 1 ? 4'h0 : 4'h4),
                    k == 2 ? 4'h8 : (k == 3 ? 4'h0 : 4'h4), 1'b0);
            pulse(k);
            v = 32'h1 << st[k];
            rdchk(A_ST, v, v, "error flag set");
            chk_irq(1'b0);
            wr(A_IE, 32'h1 << ie[k]);
            chk_irq(1'b1);
            wr(A_ST, 32'h0);
            rdchk(A_ST, v, v, "error flag hold");
            wr(A_ST, v);
            rdchk(A_ST, v, 32'h0, "error flag clr");
            chk_irq(1'b0);
            wr(A_IE, 32'h0);
        end
        // thresholds: tx 3, rx 5
        wr(A_TH, 32'h00000053);
        set_lvl(4'h2, 4'h4, 1'b0);
        wr(A_IE, 32'h00000400);
        rdchk(A_ST, 32'h40000, 32'h40000, "tx th low");
        chk_irq(1'b1);
        set_lvl(4'h5, 4'h4, 1'b0);
        rdchk(A_ST, 32'h40000, 32'h40000, "tx th kept");
        pulse(0);
        rdchk(A_ST, 32'h40000, 32'h0, "tx th fall");
        chk_irq(1'b0);
        set_lvl(4'h3, 4'h4, 1'b0);
        rdchk(A_ST, 32'h40000, 32'h40000, "tx th edge");
        wr(A_IE, 32'h00000004);
        rdchk(A_ST, 32'h400, 32'h0, "rx th below");
        chk_irq(1'b0);
        set_lvl(4'h3, 4'h5, 1'b0);
        rdchk(A_ST, 32'h400, 32'h400, "rx th reached");
        chk_irq(1'b1);
        wr(A_IE, 32'h0);
        // unmapped place, then random enables and levels
        wr(5'h14, ALL);
        rdchk(5'h14, ALL, 32'h0, "unmapped");
        rdchk(A_IE, ALL, 32'h0, "ie after unmapped");
        for (int i = 0; i < 18; i++) begin
            v = $random(seed);
            wr(A_IE, v);
            rdchk(A_IE, ALL, v & `ASI_IE_MASK, "irq_enable rw");
            t = 4'(($random(seed) & 32'h7FFFFFFF) % 9);
            r = 4'(($random(seed) & 32'h7FFFFFFF) % 9);
            if (i < 2) begin
                t = (i == 0) ? 4'h0 : 4'h8;
                r = (i == 0) ? 4'h8 : 4'h0;
            end
            set_lvl(t, r, v[5]);
            rdchk(A_ST, LIVE, exp_live(t, r, v[5]), "levels");
            wr(A_ST, 32'h00080000);
            rdchk(A_ST, LIVE, exp_live(t, r, v[5]), "full ro");
        end
        finish_test();
    end
endmodule
